// [inc/eimbp_pkg.sv]
// Shared constants for the muxed-bus memory and dual port block.
// Assumes a single 50 MHz clock; every pin input arrives asynchronously.
package eimbp_pkg;
   // -------------------------------------------------------------------
   // Widths
   // -------------------------------------------------------------------
   localparam int BUS_W   = 8;            // Muxed address/data bus
   localparam int UPPER_W = 3;            // Upper memory address inputs
   localparam int ADDR_W  = BUS_W + UPPER_W;
   localparam int DEPTH   = 2048;         // Memory bytes
   localparam int PORT_W  = 8;            // Lines per port

   // -------------------------------------------------------------------
   // Positions inside the packed pin-input vector
   // -------------------------------------------------------------------
   localparam int IN_W        = BUS_W + UPPER_W + 9;
   localparam int I_BUS_LO    = 0;
   localparam int I_UPPER_LO  = BUS_W;
   localparam int I_ALE       = BUS_W + UPPER_W;
   localparam int I_SEL_LOW_N = I_ALE + 1;
   localparam int I_SEL_HIGH  = I_ALE + 2;
   localparam int I_IO_MEM    = I_ALE + 3;
   localparam int I_MEM_RD_N  = I_ALE + 4;
   localparam int I_PORT_RD_N = I_ALE + 5;
   localparam int I_PORT_WR_N = I_ALE + 6;
   localparam int I_DEV_CLK   = I_ALE + 7;
   localparam int I_PROG      = I_ALE + 8;

   // -------------------------------------------------------------------
   // Field positions in the latched low address byte
   // -------------------------------------------------------------------
   localparam int PORT_SEL_BIT = 0;       // 0 first port, 1 second port
   localparam int DIR_SEL_BIT  = 1;       // 1 addresses direction register

   // -------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------
   localparam logic [PORT_W-1:0] PORT_RST = 8'h00;
   localparam logic [BUS_W-1:0]  BUS_RST  = 8'h00;
   localparam logic [IN_W-1:0]   IN_RST   = 20'h0_0000;
endpackage : eimbp_pkg

// [core/eimbp_port.sv]
// One 8-line general purpose port with its direction register.
// Assumes write enables are one-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module eimbp_port
#(
   parameter int WIDTH = eimbp_pkg::PORT_W
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             wr_data,
   input  wire logic             wr_dir,
   input  wire logic [WIDTH-1:0] wdata,
   input  wire logic [WIDTH-1:0] pin_i,
   output logic      [WIDTH-1:0] pin_o,
   output logic      [WIDTH-1:0] pin_oe,
   output logic      [WIDTH-1:0] rd_value
);
   import eimbp_pkg::*;

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [WIDTH-1:0] s1;    // Pin sync, first stage
      logic [WIDTH-1:0] s2;    // Pin sync, second stage
      logic [WIDTH-1:0] data;  // Output latch
      logic [WIDTH-1:0] dir;   // 1 output, 0 input
   } eimbp_port_t;

   eimbp_port_t st_r;
   eimbp_port_t st_nxt;

   if (WIDTH < 1 || WIDTH > PORT_W) begin : g_chk
      $error("eimbp_port: WIDTH out of range");
   end

   // Next state: sync pins, load data or direction on write
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pin_i;
      st_nxt.s2 = st_r.s1;
      if (wr_data) begin
         st_nxt.data = wdata;
      end
      if (wr_dir) begin
         st_nxt.dir = wdata;
      end
   end

   // State register; reset makes every line an input
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign pin_o  = st_r.data;
   assign pin_oe = st_r.dir;
   // Output lines read back the latch, input lines the pin
   assign rd_value = (st_r.dir & st_r.data) | (~st_r.dir & st_r.s2);
endmodule : eimbp_port
`default_nettype wire

// [core/eimbp_core.sv]
// Bus side of a 2048x8 memory with two 8-bit ports on a muxed bus.
// Assumes all pins are asynchronous to CLOCK and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module eimbp_core
(
   input  wire logic                          CLOCK,
   input  wire logic                          RESET_N,
   input  wire logic                          ALE,
   input  wire logic [eimbp_pkg::BUS_W-1:0]   MUXED_BUS_I,
   output logic      [eimbp_pkg::BUS_W-1:0]   MUXED_BUS_O,
   output logic                               MUXED_BUS_OE,
   input  wire logic [eimbp_pkg::UPPER_W-1:0] UPPER_ROM_ADDR,
   input  wire logic                          SELECT_LOW_N,
   input  wire logic                          SELECT_HIGH,
   input  wire logic                          IO_MEM,
   input  wire logic                          MEM_READ_N,
   input  wire logic                          PORT_READ_N,
   input  wire logic                          PORT_WRITE_N,
   input  wire logic                          DEV_CLK,
   input  wire logic                          PROG_MODE,
   output logic                               READY_O,
   output logic                               READY_OE,
   input  wire logic [eimbp_pkg::PORT_W-1:0]  PORT_FIRST_I,
   output logic      [eimbp_pkg::PORT_W-1:0]  PORT_FIRST_O,
   output logic      [eimbp_pkg::PORT_W-1:0]  PORT_FIRST_OE,
   input  wire logic [eimbp_pkg::PORT_W-1:0]  PORT_SECOND_I,
   output logic      [eimbp_pkg::PORT_W-1:0]  PORT_SECOND_O,
   output logic      [eimbp_pkg::PORT_W-1:0]  PORT_SECOND_OE
);
   import eimbp_pkg::*;

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [IN_W-1:0]    s1;        // Pin sync, first stage
      logic [IN_W-1:0]    s2;        // Pin sync, second stage
      logic               wr_p;      // Previous synced values for edges
      logic               clk_p;
      logic               ce1_p;
      logic [BUS_W-1:0]   lat_lo;    // Address latches
      logic [UPPER_W-1:0] lat_up;
      logic               lat_io;
      logic               lat_ce1_n;
      logic               lat_ce2;
      logic               rdy_val;   // Wait request pin value, 0 held
      logic               rdy_oe;
      logic [BUS_W-1:0]   bus_o;
      logic               bus_oe;
   } eimbp_state_t;

   eimbp_state_t st_r;
   eimbp_state_t st_nxt;

   logic [BUS_W-1:0]  mem [DEPTH];
   logic [BUS_W-1:0]  mem_q;
   logic [ADDR_W-1:0] mem_addr;
   logic              mem_we;
   logic [IN_W-1:0]   in_raw;
   logic [IN_W-1:0]   sy;
   logic              sel_ok;
   logic              wr_fall;
   logic              wr_first;
   logic              wr_second;
   logic              dir_first;
   logic              dir_second;
   logic [PORT_W-1:0] rd_first;
   logic [PORT_W-1:0] rd_second;
   logic [PORT_W-1:0] port_val;
   logic              rd_any;
   logic              port_rd;

   if (DEPTH != (1 << ADDR_W) || PORT_W != BUS_W) begin : g_chk
      $error("eimbp_core: memory or port size does not fit the bus");
   end

   // -------------------------------------------------------------------
   // Input gathering and decode
   // -------------------------------------------------------------------
   // Pack every pin input except the port lines for the two-stage synchroniser
   assign in_raw = {PROG_MODE, DEV_CLK, PORT_WRITE_N, PORT_READ_N,
                    MEM_READ_N, IO_MEM, SELECT_HIGH, SELECT_LOW_N, ALE,
                    UPPER_ROM_ADDR, MUXED_BUS_I};
   assign sy = st_r.s2;

   // Both selects as latched by the address strobe
   assign sel_ok = !st_r.lat_ce1_n && st_r.lat_ce2;

   // Port write strobe falling edge, routed by latched bits
   assign wr_fall    = st_r.wr_p && !sy[I_PORT_WR_N] && sel_ok
                       && !sy[I_PROG];
   assign wr_first   = wr_fall && !st_r.lat_lo[PORT_SEL_BIT]
                       && !st_r.lat_lo[DIR_SEL_BIT];
   assign wr_second  = wr_fall && st_r.lat_lo[PORT_SEL_BIT]
                       && !st_r.lat_lo[DIR_SEL_BIT];
   assign dir_first  = wr_fall && !st_r.lat_lo[PORT_SEL_BIT]
                       && st_r.lat_lo[DIR_SEL_BIT];
   assign dir_second = wr_fall && st_r.lat_lo[PORT_SEL_BIT]
                       && st_r.lat_lo[DIR_SEL_BIT];

   // Port choice by latched bit zero
   assign port_val = st_r.lat_lo[PORT_SEL_BIT] ? rd_second
                                               : rd_first;

   // Port read strobe acts as io select high plus read strobe
   assign port_rd = !sy[I_PORT_RD_N]
                    || (st_r.lat_io && !sy[I_MEM_RD_N]);
   assign rd_any  = !sy[I_PORT_RD_N] || !sy[I_MEM_RD_N];

   // -------------------------------------------------------------------
   // Memory array
   // -------------------------------------------------------------------
   // Upper inputs only ever reach the memory address
   assign mem_addr = {st_r.lat_up, st_r.lat_lo};
   // Rising edge of the low select in program mode writes a byte
   assign mem_we = sy[I_PROG] && !st_r.ce1_p && sy[I_SEL_LOW_N]
                   && st_r.lat_ce2;

   // Synchronous memory read and program write
   always_ff @(posedge CLOCK) begin
      if (mem_we) begin
         mem[mem_addr] <= sy[I_BUS_LO +: BUS_W];
      end
      mem_q <= mem[mem_addr];
   end

   // -------------------------------------------------------------------
   // Ports
   // -------------------------------------------------------------------
   eimbp_port #(.WIDTH(PORT_W)) u_first (
      .clk      (CLOCK),
      .rst_n    (RESET_N),
      .wr_data  (wr_first),
      .wr_dir   (dir_first),
      .wdata    (sy[I_BUS_LO +: BUS_W]),
      .pin_i    (PORT_FIRST_I),
      .pin_o    (PORT_FIRST_O),
      .pin_oe   (PORT_FIRST_OE),
      .rd_value (rd_first)
   );

   eimbp_port #(.WIDTH(PORT_W)) u_second (
      .clk      (CLOCK),
      .rst_n    (RESET_N),
      .wr_data  (wr_second),
      .wr_dir   (dir_second),
      .wdata    (sy[I_BUS_LO +: BUS_W]),
      .pin_i    (PORT_SECOND_I),
      .pin_o    (PORT_SECOND_O),
      .pin_oe   (PORT_SECOND_OE),
      .rd_value (rd_second)
   );

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   // Sync, address latch, wait request and bus drivers
   always_comb begin
      st_nxt       = st_r;
      st_nxt.s1    = in_raw;
      st_nxt.s2    = st_r.s1;
      st_nxt.wr_p  = sy[I_PORT_WR_N];
      st_nxt.clk_p = sy[I_DEV_CLK];
      st_nxt.ce1_p = sy[I_SEL_LOW_N];

      // Latches follow while strobe is high, hold after it falls
      if (sy[I_ALE]) begin
         st_nxt.lat_lo    = sy[I_BUS_LO +: BUS_W];
         st_nxt.lat_up    = sy[I_UPPER_LO +: UPPER_W];
         st_nxt.lat_io    = sy[I_IO_MEM];
         st_nxt.lat_ce1_n = sy[I_SEL_LOW_N];
         st_nxt.lat_ce2   = sy[I_SEL_HIGH];
      end

      // Wait request: low once selected with strobe high, released on a device clock rising edge
      if (sy[I_ALE] && !sy[I_SEL_LOW_N] && sy[I_SEL_HIGH]) begin
         st_nxt.rdy_val = 1'b0;
         st_nxt.rdy_oe  = 1'b1;
      end else if (sy[I_DEV_CLK] && !st_r.clk_p) begin
         st_nxt.rdy_val = 1'b1;
         st_nxt.rdy_oe  = 1'b0;
      end

      // Bus drivers follow the read strobes and latched selects
      if (sel_ok && rd_any && !sy[I_PROG]) begin
         st_nxt.bus_oe = 1'b1;
         st_nxt.bus_o  = port_rd ? port_val : mem_q;
      end else begin
         st_nxt.bus_oe = 1'b0;
         st_nxt.bus_o  = BUS_RST;
      end
   end

   // State register
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_r           <= '0;
         st_r.s1        <= IN_RST;
         st_r.s2        <= IN_RST;
         st_r.lat_ce1_n <= 1'b1;
         st_r.rdy_val   <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign MUXED_BUS_O  = st_r.bus_o;
   assign MUXED_BUS_OE = st_r.bus_oe;
   assign READY_O      = st_r.rdy_val;
   assign READY_OE     = st_r.rdy_oe;
endmodule : eimbp_core
`default_nettype wire

// [sim/eimbp_props.sv]
// Pin-level assertions for the muxed-bus memory and port block.
// Assumes it is bound to eimbp_core and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module eimbp_props
(
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic ALE,
   input wire logic SELECT_LOW_N,
   input wire logic SELECT_HIGH,
   input wire logic MEM_READ_N,
   input wire logic PORT_READ_N,
   input wire logic PORT_WRITE_N,
   input wire logic DEV_CLK,
   input wire logic PROG_MODE,
   input wire logic MUXED_BUS_OE,
   input wire logic READY_O,
   input wire logic READY_OE,
   input wire logic [eimbp_pkg::PORT_W-1:0] PORT_FIRST_O,
   input wire logic [eimbp_pkg::PORT_W-1:0] PORT_FIRST_OE,
   input wire logic [eimbp_pkg::PORT_W-1:0] PORT_SECOND_O,
   input wire logic [eimbp_pkg::PORT_W-1:0] PORT_SECOND_OE
);
   import eimbp_pkg::*;
   // All checks run on the system clock, quiet in reset
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   a_bus_float_idle: assert property (
      (MEM_READ_N && PORT_READ_N)[*4] |-> !MUXED_BUS_OE)
      else $error("bus driven with both read strobes high");
   a_bus_strobe_cause: assert property (
      MUXED_BUS_OE |-> !$past(MEM_READ_N, 3) || !$past(PORT_READ_N, 3))
      else $error("bus driven without a read strobe");
   a_prog_no_read: assert property (
      PROG_MODE[*4] |-> !MUXED_BUS_OE)
      else $error("bus driven in programming mode");
   a_ready_low_only: assert property (
      READY_OE |-> !READY_O)
      else $error("wait request driven high");
   a_ready_sel_cause: assert property (
      $rose(READY_OE) |-> $past(ALE, 3) && !$past(SELECT_LOW_N, 3)
      && $past(SELECT_HIGH, 3))
      else $error("wait request without selected strobe");
   a_ready_hold_clk: assert property (
      $fell(READY_OE) |-> $past(DEV_CLK, 3) && !$past(DEV_CLK, 4))
      else $error("wait request released without device clock");
   a_ready_release: assert property (
      (!ALE)[*3] ##1 ($rose(DEV_CLK) && !ALE) ##1 (DEV_CLK && !ALE)[*4]
      |-> !READY_OE)
      else $error("wait request not released by device clock");
   a_port_write_cause: assert property (
      $changed(PORT_FIRST_O) || $changed(PORT_FIRST_OE)
      || $changed(PORT_SECOND_O) || $changed(PORT_SECOND_OE)
      |-> !$past(PORT_WRITE_N, 3) && !$past(PROG_MODE, 3))
      else $error("port changed without a port write");
endmodule : eimbp_props
bind eimbp_core eimbp_props u_props (.CLOCK, .RESET_N, .ALE, .SELECT_LOW_N,
   .SELECT_HIGH, .MEM_READ_N, .PORT_READ_N, .PORT_WRITE_N, .DEV_CLK,
   .PROG_MODE, .MUXED_BUS_OE, .READY_O, .READY_OE, .PORT_FIRST_O,
   .PORT_FIRST_OE, .PORT_SECOND_O, .PORT_SECOND_OE);
`default_nettype wire

// [sim/eimbp_host.sv]
// Host processor model: muxed-bus address, read, write, program cycles.
// Assumes the caller's clock; tasks change pins 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module eimbp_host
(
   input  wire logic clk,
   input  wire logic dev_oe,
   input  wire logic [eimbp_pkg::BUS_W-1:0] dev_d,
   output logic [eimbp_pkg::BUS_W-1:0] bus,
   output logic [eimbp_pkg::UPPER_W-1:0] upper,
   output logic ale,
   output logic sel_low_n,
   output logic sel_high,
   output logic io_mem,
   output logic mem_rd_n,
   output logic port_rd_n,
   output logic port_wr_n,
   output logic dev_clk,
   output logic prog
);
   import eimbp_pkg::*;
   logic [BUS_W-1:0] drv_d;
   logic [BUS_W-1:0] last_d = 8'h00;
   logic             drv_oe;
   // Idle bus shows a changing pattern, never a stale byte
   always_comb bus = dev_oe ? dev_d : (drv_oe ? drv_d : ~last_d);
   always @(posedge clk) last_d <= bus;
   // Idle pins, then a free-running device clock
   initial begin
      {ale, drv_oe, drv_d, upper, sel_high, io_mem, prog, dev_clk} = '0;
      {sel_low_n, mem_rd_n, port_rd_n, port_wr_n} = '1;
      forever #160 dev_clk = ~dev_clk;
   end
   // Address phase with strobe held four clocks
   task addr(input logic io, input logic [10:0] a, input logic s,
             input logic pg);
      @(posedge clk) #1;
      {ale, io_mem, upper, sel_low_n, sel_high, prog} = {1'b1, io,
         a[10:8], !s, 1'b1, pg};
      drv_oe = 1;
      drv_d = a[7:0];
      repeat (4) @(posedge clk);
      #1 ale = 0;
      repeat (4) @(posedge clk);
      #1 drv_oe = 0;
   endtask : addr
   // Read holds its strobe until the bus is driven, or gives up
   task rd(input logic port, output logic [7:0] d, output logic ok);
      @(posedge clk) #1;
      if (port) port_rd_n = 0;
      else mem_rd_n = 0;
      ok = 0;
      for (int n = 0; n < 8 && !ok; n++) begin
         @(posedge clk);
         ok = dev_oe;
         d = dev_d;
      end
      #1 {port_rd_n, mem_rd_n} = 2'b11;
   endtask : rd
   // Port write, or programming pulse when pg is set
   task wr(input logic [7:0] d, input logic pg);
      @(posedge clk) #1 {drv_oe, drv_d} = {1'b1, d};
      repeat (3) @(posedge clk);
      #1 if (pg) sel_low_n = 1;
      else port_wr_n = 0;
      repeat (6) @(posedge clk);
      #1 {port_wr_n, prog} = 2'b10;
      repeat (3) @(posedge clk);
      #1 drv_oe = 0;
   endtask : wr
endmodule : eimbp_host
`default_nettype wire

// [sim/eimbp_io_muxed_bus_port_tb_top.sv]
// Self-checking bench for eimbp_core with a host model on its bus.
// Assumes the checker is bound in by its own file.
`timescale 1ns/1ps
`default_nettype none
module eprom_io_muxed_bus_port_tb_top;
   import eimbp_pkg::*;
   logic clk, rst_n = 0, ale, sl_n, sh, io, mrd_n, prd_n, pwr_n, dclk, prog;
   logic bus_oe, rdy_o, rdy_oe, rdy_seen, ok;
   logic [7:0] bus_i, bus_o, pa_i, pa_o, pa_oe, pb_i, pb_o, pb_oe, d;
   logic [2:0] up;
   int mismatches = 0, n_compared = 0, cyc = 0;
   // Port pins: driven lines read back, input lines see outside levels
   assign pa_i = (pa_oe & pa_o) | (~pa_oe & 8'h3C);
   assign pb_i = (pb_oe & pb_o) | (~pb_oe & 8'hC3);
   eimbp_core dut (.CLOCK(clk), .RESET_N(rst_n), .ALE(ale),
      .MUXED_BUS_I(bus_i), .MUXED_BUS_O(bus_o), .MUXED_BUS_OE(bus_oe),
      .UPPER_ROM_ADDR(up), .SELECT_LOW_N(sl_n), .SELECT_HIGH(sh),
      .IO_MEM(io), .MEM_READ_N(mrd_n), .PORT_READ_N(prd_n),
      .PORT_WRITE_N(pwr_n), .DEV_CLK(dclk), .PROG_MODE(prog),
      .READY_O(rdy_o), .READY_OE(rdy_oe), .PORT_FIRST_I(pa_i),
      .PORT_FIRST_O(pa_o), .PORT_FIRST_OE(pa_oe), .PORT_SECOND_I(pb_i),
      .PORT_SECOND_O(pb_o), .PORT_SECOND_OE(pb_oe));
   eimbp_host h (.clk(clk), .dev_oe(bus_oe), .dev_d(bus_o), .bus(bus_i),
      .upper(up), .ale(ale), .sel_low_n(sl_n), .sel_high(sh),
      .io_mem(io), .mem_rd_n(mrd_n), .port_rd_n(prd_n),
      .port_wr_n(pwr_n), .dev_clk(dclk), .prog(prog));
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task end_sim;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   // Clock, hang limit and wait-request watch
   initial begin
      clk = 0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (rdy_oe === 1'b1 && rdy_o === 1'b0) rdy_seen = 1;
      if (cyc == 6000) begin
         mismatches++;
         end_sim();
      end
   end
   // Program three bytes then read them back with wait requests
   task t_mem;
      logic [10:0] a [3] = '{11'h000, 11'h7FF, 11'h2A5};
      for (int i = 0; i < 3; i++) begin
         h.addr(0, a[i], 1, 1);
         h.wr(a[i][7:0] ^ {a[i][10:8], 5'h15}, 1);
      end
      for (int i = 0; i < 3; i++) begin
         repeat (20) @(posedge clk); // Let the last wait request end
         rdy_seen = 0;
         h.addr(0, a[i], 1, 0);
         chk("ready", 8'h01, {7'h0, rdy_seen});
         h.rd(0, d, ok);
         chk("mem_ok", 8'h01, {7'h0, ok});
         chk("mem", a[i][7:0] ^ {a[i][10:8], 5'h15}, d);
      end
      $display("t_mem done");
   endtask : t_mem
   // Direction and data writes to both ports, then both read forms
   task t_port;
      h.addr(1, 11'h702, 1, 0);
      h.wr(8'h0F, 0);
      h.addr(0, 11'h001, 1, 0);
      h.wr(8'hA5, 0);
      h.addr(1, 11'h003, 1, 0);
      h.wr(8'hF0, 0);
      h.addr(1, 11'h000, 1, 0);
      h.wr(8'h96, 0);
      chk("pa_oe", 8'h0F, pa_oe);
      chk("pa_o", 8'h96, pa_o);
      chk("pb_oe", 8'hF0, pb_oe);
      chk("pb_o", 8'hA5, pb_o);
      h.addr(0, 11'h500, 1, 0);
      h.rd(1, d, ok);
      chk("pa_rd", 8'h36, d);
      h.addr(1, 11'h001, 1, 0);
      h.rd(0, d, ok);
      chk("pb_rd", 8'hA3, d);
      $display("t_port done");
   endtask : t_port
   // Deselected cycle: no wait, no drive, no write
   task t_desel;
      repeat (20) @(posedge clk); // Let the last wait request end
      rdy_seen = 0;
      h.addr(1, 11'h000, 0, 0);
      h.wr(8'hFF, 0);
      h.rd(1, d, ok);
      chk("desel_ok", 8'h00, {7'h0, ok});
      chk("desel_rdy", 8'h00, {7'h0, rdy_seen});
      chk("desel_pa", 8'h96, pa_o);
      $display("t_desel done");
   endtask : t_desel
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      #1 rst_n = 1;
      repeat (3) @(posedge clk);
      chk("rst_pa_oe", 8'h00, pa_oe);
      chk("rst_pb_oe", 8'h00, pb_oe);
      t_mem();
      t_port();
      t_desel();
      end_sim();
   end
endmodule : eprom_io_muxed_bus_port_tb_top
`default_nettype wire
